// ---- hdl/dpram_host_pkg.sv ----
/*
 package for the host-side controller of an asynchronous dual-port
 memory with shared flags. assumes one 25 MHz clock in the host.
*/
package dpram_host_pkg;
   localparam int ADDR_W = 14;
   localparam int DATA_W = 9;
   localparam int FLAG_SEL_W = 3;
   localparam int CLK_PERIOD_NS = 40;
   // least write pulse, read cycle, flag update pulse, busy hold in ns
   localparam int WRITE_PULSE_NS = 20;
   localparam int READ_CYCLE_NS = 25;
   localparam int FLAG_PULSE_NS = 10;
   localparam int BUSY_HOLD_NS = 17;
   localparam int WRITE_PULSE_CYC =
      (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int READ_CYC = (READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FLAG_PULSE_CYC =
      (FLAG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BUSY_HOLD_CYC =
      (BUSY_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] CNT_ZERO = 4'h0;
   localparam logic [8:0] DATA_ZERO = 9'h000;
   localparam logic [13:0] ADDR_ZERO = 14'h0000;

   typedef struct packed {
      logic flag;   // 1: semaphore access, 0: memory access
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } req_t;

   typedef struct packed {
      logic chip_select_n;
      logic read_write;
      logic output_enable_n;
      logic flag_select_n;
   } port_ctl_t;

   localparam port_ctl_t CTL_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1};
endpackage

// ---- hdl/dpram_host.sv ----
/*
 host controller for one port of the dual-port memory. drives the
 port pins with a setup / strobe / recovery sequence per request.
 assumes the memory port sits on the pins directly and its signals are
 synchronous to i_mclk; the busy pin is sampled directly.
*/
`timescale 1ns/1ps

// Functional notes
// - each port is independent; this controller drives one port alone.
// - chip select low writes when read/write low, reads with output enable.
// - flag write loads the addressed flag from data bit zero only.
// - chip select and flag select are never low together.
// - several devices widen memory; one master drives busy.
// - read/write or chip select stays high while address changes.
module dpram_host (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_req_valid,
   input wire dpram_host_pkg::req_t i_req,
   output logic o_req_ready,
   output logic o_rsp_valid,
   output logic [8:0] o_rsp_data,
   output logic o_granted,
   output logic o_chip_select_n,
   output logic o_read_write,
   output logic o_output_enable_n,
   output logic o_flag_select_n,
   output logic [13:0] o_port_address,
   output logic [8:0] o_port_data_out,
   output logic o_port_data_oe,
   input wire logic [8:0] i_port_data_in,
   input wire logic i_busy_n
);
   typedef enum {idle, setup, strobe, hold, recover} state_t;
   state_t state, next_state;
   dpram_host_pkg::port_ctl_t ctl, next_ctl;
   dpram_host_pkg::req_t cur, next_cur;
   logic [3:0] cnt, next_cnt;
   logic rsp_valid, next_rsp_valid;
   logic [8:0] rsp_data, next_rsp_data;
   logic granted, next_granted;
   logic drive, next_drive;

   // sequence: address first with strobes high, then strobe, then release
   always_comb begin
      next_state = state;
      next_ctl = ctl;
      next_cur = cur;
      next_cnt = cnt;
      next_rsp_valid = 1'b0;
      next_rsp_data = rsp_data;
      next_granted = granted;
      next_drive = drive;
      case (state)
         idle: begin
            next_ctl = dpram_host_pkg::CTL_IDLE;
            next_drive = 1'b0;
            if (i_req_valid) begin
               next_cur = i_req;
               // flag access: only the three low address lines and bit zero
               if (i_req.flag) begin
                  next_cur.addr = {11'h000, i_req.addr[2:0]};
                  next_cur.data = {8'h00, i_req.data[0]};
               end
               next_state = setup;
            end
         end
         setup: begin
            // exactly one select low, never both
            next_ctl.chip_select_n = cur.flag;
            next_ctl.flag_select_n = ~cur.flag;
            next_ctl.read_write = ~cur.write;
            next_ctl.output_enable_n = cur.write;
            next_drive = cur.write;
            next_cnt = 4'(cur.flag ? dpram_host_pkg::FLAG_PULSE_CYC
                      : (cur.write ? dpram_host_pkg::WRITE_PULSE_CYC
                         : dpram_host_pkg::READ_CYC));
            next_state = strobe;
         end
         strobe: begin
            // a busy port keeps a memory access strobe until busy lifts; flag accesses ignore busy
            if (cnt > 4'h1) begin
               next_cnt = cnt - 4'h1;
            end else if (!cur.flag && !i_busy_n) begin
               next_cnt = 4'(dpram_host_pkg::BUSY_HOLD_CYC);
            end else begin
               next_rsp_data = i_port_data_in;
               next_granted = ~i_port_data_in[0];
               next_ctl.read_write = 1'b1;
               next_ctl.output_enable_n = 1'b1;
               next_state = hold;
            end
         end
         hold: begin
            // deselect before the address may change
            next_ctl = dpram_host_pkg::CTL_IDLE;
            next_drive = 1'b0;
            next_state = recover;
         end
         recover: begin
            next_rsp_valid = 1'b1;
            next_state = idle;
         end
         default: next_state = idle;
      endcase
   end

   // state registers
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state <= idle;
         ctl <= dpram_host_pkg::CTL_IDLE;
         cur <= '0;
         cnt <= dpram_host_pkg::CNT_ZERO;
         rsp_valid <= 1'b0;
         rsp_data <= dpram_host_pkg::DATA_ZERO;
         granted <= 1'b0;
         drive <= 1'b0;
      end else begin
         state <= next_state;
         ctl <= next_ctl;
         cur <= next_cur;
         cnt <= next_cnt;
         rsp_valid <= next_rsp_valid;
         rsp_data <= next_rsp_data;
         granted <= next_granted;
         drive <= next_drive;
      end
   end

   // pin drive; flag writes carry the value on bit zero
   assign o_req_ready = (state == idle);
   assign o_rsp_valid = rsp_valid;
   assign o_rsp_data = rsp_data;
   assign o_granted = granted;
   assign o_chip_select_n = ctl.chip_select_n;
   assign o_read_write = ctl.read_write;
   assign o_output_enable_n = ctl.output_enable_n;
   assign o_flag_select_n = ctl.flag_select_n;
   // address and data come straight from the captured request
   assign o_port_address = cur.addr;
   assign o_port_data_out = cur.data;
   assign o_port_data_oe = drive;

   // pin protocol checks on the host clock, quiet while in reset
   a_no_both_selects: assert property (@(posedge i_mclk)
      disable iff (!i_rst_n)
      !(!o_chip_select_n && !o_flag_select_n))
      else $error("chip and flag select low together");
   a_addr_stable_strobe: assert property (@(posedge i_mclk)
      disable iff (!i_rst_n)
      (!o_read_write && !$past(o_read_write)) |-> $stable(o_port_address))
      else $error("address moved during write strobe");
   a_idle_deselect: assert property (@(posedge i_mclk)
      disable iff (!i_rst_n)
      (state == idle) |-> (o_chip_select_n && o_flag_select_n))
      else $error("port selected while idle");
   a_oe_drive_excl: assert property (@(posedge i_mclk)
      disable iff (!i_rst_n)
      !(o_port_data_oe && !o_output_enable_n))
      else $error("host drives while port output enabled");

   // a busy port holds its memory access strobe; the answer follows the release
   a_busy_blocks: assert property (@(posedge i_mclk)
      disable iff (!i_rst_n)
      (state == strobe && cnt == 4'h1 && !cur.flag && !i_busy_n)
      |=> (state == strobe))
      else $error("write released while busy");
   a_done_pulse: assert property (@(posedge i_mclk)
      disable iff (!i_rst_n)
      (state == hold) |=> ##1 o_rsp_valid)
      else $error("response missing after access");

   // the address only moves while every strobe is high
   a_addr_move_idle: assert property (@(posedge i_mclk)
      disable iff (!i_rst_n)
      $changed(o_port_address)
      |-> (o_read_write && o_chip_select_n && o_flag_select_n))
      else $error("address moved with a strobe low");
   a_write_end_rw: assert property (@(posedge i_mclk)
      disable iff (!i_rst_n)
      $rose(o_read_write) |-> !(o_chip_select_n && o_flag_select_n))
      else $error("select released before read/write");

   // data lines: host drives on writes only, device on reads only
   a_write_drives: assert property (@(posedge i_mclk)
      disable iff (!i_rst_n)
      (!o_read_write && !(o_chip_select_n && o_flag_select_n))
      |-> o_port_data_oe)
      else $error("write strobe without host data");
   a_oe_read_only: assert property (@(posedge i_mclk)
      disable iff (!i_rst_n)
      !o_output_enable_n |-> o_read_write)
      else $error("output enable low during a write");

   // a flag access uses only the three low address lines and data bit zero
   a_flag_addr_low: assert property (@(posedge i_mclk)
      disable iff (!i_rst_n)
      !o_flag_select_n |-> (o_port_address[13:3] == 11'h000))
      else $error("flag access with high address lines set");
   a_flag_data_bit: assert property (@(posedge i_mclk)
      disable iff (!i_rst_n)
      (!o_flag_select_n && o_port_data_oe)
      |-> (o_port_data_out[8:1] == 8'h00))
      else $error("flag write drives more than bit zero");

   // the done pulse lasts exactly one cycle
   a_rsp_one_cycle: assert property (@(posedge i_mclk)
      disable iff (!i_rst_n)
      o_rsp_valid |=> !o_rsp_valid)
      else $error("response held longer than one cycle");
endmodule

// ---- verification/dpram_dev_model.sv ----
/*
 behavioural model of one memory port with eight shared flags.
 assumes a single host drives the port pins; i_stall forces busy low.
*/
`timescale 1ns/1ps
module dpram_dev_model (
   input wire logic i_cs_n,
   input wire logic i_rw,
   input wire logic i_oe_n,
   input wire logic i_sem_n,
   input wire logic [13:0] i_addr,
   input wire logic [8:0] i_din,
   input wire logic i_stall,
   output logic [8:0] o_dout,
   output logic o_busy_n
);
   logic [8:0] mem [0:16383];
   logic [7:0] flag = 8'hFF;
   logic [8:0] last = 9'h000;
   logic [8:0] rd;
   logic wen;
   logic drv;
   // exactly one select low makes a strobe; busy blocks the write
   assign wen = ~i_rw & (i_cs_n ^ i_sem_n) & o_busy_n;
   assign drv = i_rw & ~i_oe_n & (i_cs_n ^ i_sem_n);
   // stall stands for the other port arriving first at the same word
   assign o_busy_n = ~i_stall;
   assign rd = !i_cs_n ? mem[i_addr] : {9{flag[i_addr[2:0]]}};
   // released lines show the inverse of the last word, not a stale copy
   assign o_dout = drv ? rd : ~last;
   always @(negedge drv) last <= rd;
   // store at the end of the strobe; one strobe edge owns a flag at a time
   always @(negedge wen) begin
      if (!i_cs_n)
         mem[i_addr] = i_din;
      else if (!i_sem_n)
         flag[i_addr[2:0]] = i_din[0];
   end
endmodule

// ---- verification/tb_dpram_host.sv ----
/*
 testbench for the port controller, with the device model on the pins.
 assumes a 25 MHz clock and inputs driven on the falling edge.
*/
`timescale 1ns/1ps
module tb_dpram_host;
   logic i_mclk = 1'b0;
   logic i_rst_n = 1'b0;
   logic vld = 1'b0;
   dpram_host_pkg::req_t req = '0;
   logic stall = 1'b0;
   logic rdy, rv, gnt, cs_n, rw, oe_n, sem_n, doe;
   logic dev_busy_n;
   logic [8:0] rdata, hout, dout, pin;
   logic [13:0] addr;
   int n_mismatch = 0;
   int checks = 0;
   int cyc = 0;
   int lat, lat0, i;
   always #20 i_mclk = ~i_mclk;
   // shared data wire resolved from the host's enable
   assign pin = doe ? hout : dout;
   dpram_host dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_req_valid(vld),
      .i_req(req), .o_req_ready(rdy), .o_rsp_valid(rv), .o_rsp_data(rdata),
      .o_granted(gnt), .o_chip_select_n(cs_n), .o_read_write(rw),
      .o_output_enable_n(oe_n), .o_flag_select_n(sem_n),
      .o_port_address(addr), .o_port_data_out(hout), .o_port_data_oe(doe),
      .i_port_data_in(pin), .i_busy_n(dev_busy_n));
   dpram_dev_model dev (.i_cs_n(cs_n), .i_rw(rw), .i_oe_n(oe_n),
      .i_sem_n(sem_n), .i_addr(addr), .i_din(pin), .i_stall(stall),
      .o_dout(dout), .o_busy_n(dev_busy_n));
   task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // one request, held until taken, then a bounded wait for the answer
   task xfer(input logic f, w, input logic [13:0] a, input logic [8:0] d);
      vld = 1'b1;
      req = '{f, w, a, d};
      lat = 0;
      // ready seen at a falling edge means the next rising edge takes it
      while (rdy !== 1'b1)
         @(negedge i_mclk);
      @(negedge i_mclk);
      vld = 1'b0;
      while (rv !== 1'b1 && lat < 30) begin
         @(negedge i_mclk);
         lat++;
      end
      chk({8'h00, rv}, 9'h001);
   endtask
   task t_mem;
      xfer(1'b0, 1'b1, 14'h3FFF, 9'h1A5);
      xfer(1'b0, 1'b1, 14'h0001, 9'h05A);
      lat0 = lat;
      xfer(1'b0, 1'b0, 14'h3FFF, 9'h000);
      chk(rdata, 9'h1A5);
      xfer(1'b0, 1'b0, 14'h0001, 9'h000);
      chk(rdata, 9'h05A);
      chk({5'h00, cs_n, rw, oe_n, sem_n}, 9'h00F);
   endtask
   // every flag: request, read back through aliased address, release
   task t_flag;
      for (i = 0; i < 8; i++) begin
         xfer(1'b1, 1'b1, 14'(i * 9), 9'h1FE);
         xfer(1'b1, 1'b0, 14'(i + 40), 9'h000);
         chk(rdata, 9'h000);
         chk({8'h00, gnt}, 9'h001);
         xfer(1'b1, 1'b0, 14'(i ^ 1), 9'h000);
         chk(rdata, 9'h1FF);
         xfer(1'b1, 1'b1, 14'(i), 9'h001);
         xfer(1'b1, 1'b0, 14'(i), 9'h000);
         chk({8'h00, gnt}, 9'h000);
      end
   endtask
   task t_busy;
      stall = 1'b1;
      fork
         xfer(1'b0, 1'b1, 14'h0002, 9'h0C3);
         begin
            repeat (4) @(negedge i_mclk);
            stall = 1'b0;
         end
      join
      chk({8'h00, lat > lat0}, 9'h001);
      xfer(1'b0, 1'b0, 14'h0002, 9'h000);
      chk(rdata, 9'h0C3);
   endtask
   // reset in mid-request abandons it; the next access works as normal
   task t_reset;
      vld = 1'b1;
      req = '{1'b0, 1'b0, 14'h0002, 9'h000};
      @(negedge i_mclk);
      vld = 1'b0;
      i_rst_n = 1'b0;
      @(negedge i_mclk);
      chk({5'h00, cs_n, rw, oe_n, sem_n}, 9'h00F);
      chk({7'h00, rdy, rv}, 9'h002);
      i_rst_n = 1'b1;
      @(negedge i_mclk);
      xfer(1'b0, 1'b0, 14'h0002, 9'h000);
      chk(rdata, 9'h0C3);
   endtask
   // pin watch and hang limit
   always @(negedge i_mclk) begin
      cyc++;
      if (i_rst_n)
         chk({8'h00, cs_n | sem_n}, 9'h001);
      if (!oe_n)
         chk({8'h00, doe}, 9'h000);
      if (!sem_n)
         chk({8'h00, |addr[13:3]}, 9'h000);
      if (cyc == 3000) begin
         n_mismatch++;
         summarize;
      end
   end
   initial begin
      repeat (6) @(posedge i_mclk);
      @(negedge i_mclk);
      chk({5'h00, cs_n, rw, oe_n, sem_n}, 9'h00F);
      i_rst_n = 1'b1;
      @(negedge i_mclk);
      t_mem;
      t_flag;
      t_busy;
      t_reset;
      summarize;
   end
endmodule
